// ===== dv/reset_line_model.sv
`timescale 1ns/1ns
module reset_line_model (
  input  wire logic oe_n,     // Device drive enable.
  input  wire logic out_val,  // Device drive value.
  input  wire logic pull_low, // Board pulls low.
  output logic      line      // Resolved level.
);
  // The line has a pull-up, so it is high unless some party pulls it low.
  assign line = !(pull_low || (!oe_n && !out_val));
endmodule

// ===== dv/stop_recovery_properties.sv
`timescale 1ns/1ns
module stop_recovery_properties
  import stop_recovery_pkg::*;
(
  input wire logic        sys_clk,                 // Clock.
  input wire logic        nrst,                    // Reset.
  input wire logic [4:0]  avs_address,             // Address.
  input wire logic        avs_read,                // Read.
  input wire logic        avs_write,               // Write.
  input wire logic [31:0] avs_writedata,           // Write data.
  input wire logic        avs_waitrequest,         // Wait.
  input wire logic        reset_pin_out,           // Pin value.
  input wire logic        reset_pin_oe_n,          // Pin enable.
  input wire logic        wdt_timeout,             // Watchdog.
  input wire logic        system_reset,            // Chip reset.
  input wire logic        cpu_hold,                // Hold.
  input wire logic        vector_fetch,            // Fetch.
  input wire logic [15:0] vector_addr,             // Fetch address.
  input wire logic        dco_select,              // Clock select.
  input wire logic        dco_load,                // Code load.
  input wire logic        frequency_locked_loop,   // Loop enable.
  input wire logic        stop_mode,               // Stop.
  input wire logic        global_interrupt_enable, // Enable.
  input wire logic        wdt_irq                  // Watchdog request.
);
  logic        fast_q;
  logic [15:0] run_len;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fast_q  <= 1'b0;
      run_len <= 16'h0000;
    end else begin
      if (system_reset) begin
        fast_q <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == ADDR_CONTROL) begin
        fast_q <= avs_writedata[CT_FAST];
      end
      run_len <= system_reset ? run_len + 16'h0001 : 16'h0000;
    end
  end

  sequence fetch_hi_s;
    vector_fetch && vector_addr == VECTOR_ADDR_HI;
  endsequence
  sequence fetch_lo_s;
    vector_fetch && vector_addr == VECTOR_ADDR_LO;
  endsequence

  chk_pin_driven_low: assert property ($rose(system_reset) |-> ##[0:1] !reset_pin_oe_n)
    else $error("reset pin not driven during reset");
  chk_pin_value_zero: assert property (!reset_pin_oe_n |-> !reset_pin_out)
    else $error("reset pin driven high");
  chk_reset_length: assert property ($fell(system_reset) |-> run_len >= RESET_DELAY_COUNT - 16'h0001)
    else $error("reset shorter than delay");
  chk_fast_latency: assert property ($fell(stop_mode) && !system_reset && fast_q |-> ##[5:9] fetch_hi_s)
    else $error("fast recovery latency wrong");
  chk_slow_latency: assert property ($fell(stop_mode) && !system_reset && !fast_q |-> ##[205:209] fetch_hi_s)
    else $error("slow recovery latency wrong");
  chk_fetch_order: assert property (fetch_hi_s |=> fetch_lo_s)
    else $error("vector bytes out of order");
  chk_recover_state: assert property ($fell(stop_mode) && !system_reset |-> ##[0:1] (dco_load && dco_select && !frequency_locked_loop && !global_interrupt_enable))
    else $error("recovery clock or enable state wrong");
  chk_stop_loop_off: assert property (stop_mode |-> !frequency_locked_loop)
    else $error("loop enabled in stop");
  chk_hold_processor: assert property (stop_mode || vector_fetch |-> cpu_hold)
    else $error("processor not held");
  chk_wdt_read_clear: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_STATUS && !wdt_timeout |=> !wdt_irq)
    else $error("watchdog request not withdrawn");
endmodule

bind stop_recovery_reset_indicator stop_recovery_properties i_stop_recovery_properties (.*);

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  import stop_recovery_pkg::*;
  logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest, reset_pin_in, reset_pin_out;
  logic reset_pin_oe_n, debug_pin_in, por_event, wdt_timeout, lvd_level, pull_low, system_reset;
  logic cpu_hold, vector_fetch, dco_select, dco_load, frequency_locked_loop, osc_run, stop_mode;
  logic global_interrupt_enable, wdt_irq, timer_event, comparator_out, rtc_event, lvd_event;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] vector_addr;
  logic [7:0]  dco_code, port_pins, port_irq, port_input_data;
  logic [3:0]  src;
  int          n_errors, check_count, n;

  assign {lvd_event, rtc_event, comparator_out, timer_event} = src;
  stop_recovery_reset_indicator i_stop_recovery_reset_indicator (.*);
  reset_line_model i_reset_line_model (.oe_n(reset_pin_oe_n), .out_val(reset_pin_out),
    .pull_low(pull_low), .line(reset_pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Bus access and sequence helpers
  // ---------------------------------------------------------------------------
  task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic expect_reg(input logic [4:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic enter_stop(input logic [31:0] ctrl);
    access(1'b1, ADDR_CONTROL, ctrl);
    repeat (2) @(posedge sys_clk);
    check(32'(stop_mode && !frequency_locked_loop), 1);
  endtask

  task automatic wait_fetch(input int lo);
    n = 0;
    while (!vector_fetch && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n >= lo - 1 && n <= lo + 6), 1);
    check(vector_addr, 16'h0002);
    @(posedge sys_clk);
    check({vector_fetch, vector_addr}, {1'b1, 16'h0003});
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wait_reset();
    logic bad;
    bad = 1'b0;
    n = 0;
    repeat (8) if (!system_reset) @(posedge sys_clk);
    @(posedge sys_clk);
    while (system_reset && n < 1100) begin
      bad |= reset_pin_in;
      @(posedge sys_clk);
      n++;
    end
    check(bad, 1'b0);
    check(32'(n >= RESET_DELAY_CYCLES - 3 && n <= RESET_DELAY_CYCLES + 4), 1);
    repeat (6) @(posedge sys_clk);
  endtask

  initial begin
    #3_000_000;
    n_errors++;
    complete_run();
  end

  initial begin
    {nrst, avs_read, avs_write, por_event, wdt_timeout, lvd_level, pull_low} = '0;
    {avs_address, avs_writedata, port_pins, src} = '0;
    debug_pin_in = 1'b1;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    lvd_level <= 1'b1;
    expect_reg(ADDR_STATUS, 32'h0000_0001);
    expect_reg(ADDR_STATUS, 32'h0000_0001);
    lvd_level <= 1'b0;
    access(1'b1, 5'h14, 32'hFFFF_FFFF);
    expect_reg(5'h14, 32'h0000_0000);
    por_event <= 1'b1;
    @(posedge sys_clk) por_event <= 1'b0;
    wait_reset();
    expect_reg(ADDR_STATUS, 32'h0000_0080);
    expect_reg(ADDR_STATUS, 32'h0000_0000);
    pull_low <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pull_low <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(system_reset, 1'b0);
    enter_stop(32'h0000_0180);
    pull_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    pull_low <= 1'b0;
    wait_reset();
    expect_reg(ADDR_STATUS, 32'h0000_0010);
    access(1'b1, ADDR_CONTROL, 32'h0000_0101);
    wait_reset();
    expect_reg(ADDR_CONTROL, 32'h0000_0100);
    expect_reg(ADDR_STATUS, 32'h0000_0080);
    enter_stop(32'h0000_0180);
    debug_pin_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    debug_pin_in <= 1'b1;
    wait_reset();
    access(1'b1, ADDR_CLOCK, 32'h0000_005A);
    for (int i = 0; i < 4; i++) begin
      access(1'b1, ADDR_WAKE, 32'(1 << i));
      enter_stop(32'h0000_01E6);
      check(osc_run, 1'b1);
      src <= 4'(1 << ((i + 1) % 4));
      repeat (4) @(posedge sys_clk);
      check(stop_mode, 1'b1);
      src <= 4'(1 << i);
      wait_fetch(RECOVERY_TAIL_CYCLES);
      src <= 4'h0;
      check({dco_select, frequency_locked_loop, global_interrupt_enable, dco_code},
            {3'b100, 8'h5A});
      expect_reg(ADDR_STATUS, 32'h0000_0040);
      expect_reg(ADDR_WAKE, 32'(1 << i));
    end
    access(1'b1, ADDR_WAKE, 32'h0000_0000);
    enter_stop(32'h0000_01B0);
    check(osc_run, 1'b0);
    wdt_timeout <= 1'b1;
    @(posedge sys_clk) wdt_timeout <= 1'b0;
    wait_fetch(RECOVERY_DELAY_CYCLES + RECOVERY_TAIL_CYCLES);
    check({osc_run, wdt_irq}, 2'b11);
    expect_reg(ADDR_STATUS, 32'h0000_0060);
    @(posedge sys_clk);
    check(wdt_irq, 1'b0);
    expect_reg(ADDR_STATUS, 32'h0000_0000);
    access(1'b1, ADDR_WAKE, 32'h0000_0100);
    access(1'b1, ADDR_PORT, 32'h0000_0001);
    enter_stop(32'h0000_01A2);
    port_pins <= 8'h01;
    wait_fetch(RECOVERY_TAIL_CYCLES);
    check(port_input_data, 8'h01);
    check(port_irq, 8'h00);
    expect_reg(ADDR_PORT, 32'h0001_0101);
    access(1'b1, ADDR_CONTROL, 32'h0000_0140);
    repeat (2) @(posedge sys_clk);
    check(port_irq, 8'h01);
    access(1'b1, ADDR_PORT, 32'h0000_0101);
    enter_stop(32'h0000_01A2);
    port_pins <= 8'h00;
    @(posedge sys_clk) port_pins <= 8'h01;
    wait_fetch(RECOVERY_TAIL_CYCLES);
    expect_reg(ADDR_PORT, 32'h0001_0001);
    complete_run();
  end
endmodule

// ===== src/delay_timer.sv
`timescale 1ns/1ns
module delay_timer
  import stop_recovery_pkg::*;
(
  input wire logic  sys_clk, // System clock.
  input wire logic  nrst,    // Asynchronous reset, active low.
  delay_timer_if.timer tmr   // Start, count and done.
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  // Done pulses count cycles after start is seen; a new start restarts it.
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (tmr.start) begin
      next_s.cnt  = tmr.count;
      next_s.busy = 1'b1;
    end else if (s.busy) begin
      next_s.cnt = s.cnt - 16'h0001;
      if (s.cnt <= 16'h0001) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.done = s.done;
endmodule

// ===== src/delay_timer_if.sv
`timescale 1ns/1ns
interface delay_timer_if;
  logic        start;
  logic [15:0] count;
  logic        done;

  modport ctrl  (output start, output count, input done);
  modport timer (input start, input count, output done);
endinterface

// ===== src/pin_low_filter.sv
`timescale 1ns/1ns
module pin_low_filter
  import stop_recovery_pkg::*;
(
  input  wire logic sys_clk, // System clock.
  input  wire logic nrst,    // Asynchronous reset, active low.
  input  wire logic pin_n,   // Pin level, low is asserted.
  output logic      low_seen // Pin held low long enough.
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       low;
  } filter_state_t;

  filter_state_t s;
  filter_state_t next_s;

  // Low pulses shorter than the minimum width never reach low_seen.
  always_comb begin
    next_s = s;
    if (pin_n) begin
      next_s.cnt = 3'h0;
      next_s.low = 1'b0;
    end else if (s.cnt >= 3'(PIN_MIN_LOW_CYCLES - 1)) begin
      next_s.low = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign low_seen = s.low;
endmodule

// ===== src/stop_recovery_pkg.sv
package stop_recovery_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 100;
  localparam int RESET_DELAY_NS        = 100_000;
  localparam int RESET_DELAY_CYCLES    = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_DELAY_NS     = 20_000;
  localparam int RECOVERY_DELAY_CYCLES =
    (RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_TAIL_CYCLES  = 6;
  localparam int PIN_MIN_LOW_CYCLES    = 4;

  localparam logic [15:0] RESET_DELAY_COUNT = 16'(RESET_DELAY_CYCLES);
  localparam logic [15:0] FAST_RECOV_COUNT  = 16'(RECOVERY_TAIL_CYCLES);
  localparam logic [15:0] SLOW_RECOV_COUNT  =
    16'(RECOVERY_DELAY_CYCLES + RECOVERY_TAIL_CYCLES);

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_CONTROL  = 5'h04;
  localparam logic [4:0] ADDR_WAKE     = 5'h08;
  localparam logic [4:0] ADDR_PORT     = 5'h0C;
  localparam logic [4:0] ADDR_CLOCK    = 5'h10;

  // Status field positions.
  localparam int ST_POR  = 7;
  localparam int ST_STOP = 6;
  localparam int ST_WDT  = 5;
  localparam int ST_EXT  = 4;
  localparam int ST_LVD  = 0;

  // Control field positions.
  localparam int CT_DBG_RST   = 0;
  localparam int CT_FAST      = 1;
  localparam int CT_KEEP      = 2;
  localparam int CT_PIN_OUT   = 3;
  localparam int CT_WDT_IRQ   = 4;
  localparam int CT_FLL       = 5;
  localparam int CT_GIE       = 6;
  localparam int CT_STOP      = 7;
  localparam int CT_OSC_EN    = 8;
  localparam int CT_CLK_ALT   = 9;

  localparam logic [7:0]  DCO_CODE_RESET = 8'h80;
  localparam logic [15:0] VECTOR_ADDR_HI = 16'h0002;
  localparam logic [15:0] VECTOR_ADDR_LO = 16'h0003;
  localparam int          PORT_COUNT     = 8;

  typedef enum logic [2:0] {
    RUN, STOP, RECOVER, FETCH_HI, FETCH_LO, SYS_RESET
  } seq_state_t;

endpackage

// ===== src/stop_recovery_reset_indicator.sv
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Reset pin is driven low open-drain during system reset or when enabled.
// - Internal reset events hold the reset pin low for the whole reset delay.
// - Debugger reset request resets the chip except the debugger itself.
// - Debugger reset request bit clears itself during the system reset.
// - After a debugger reset completes the power-on flag is set.
// - Recovery changes only status, clock control, interrupt control state and port input data.
// - Recovery reloads the last oscillator code and selects it, loop disabled.
// - Enabled oscillator runs in stop if keep bit set, else halts and restarts.
// - Entering stop disables the frequency loop until software re-enables it.
// - Recovery takes 6 cycles when fast, else analog delay plus 6 cycles.
// - After recovery the restart vector is fetched from 0002h and 0003h.
// - Recovery sets the stop flag and clears the global interrupt enable.
// - Peripherals other than the watchdog wake the device only when enabled as wake sources.
// - Watchdog time-out in stop recovers and sets watchdog and stop flags.
// - Reading status clears the watchdog flag and its pending interrupt.
// - Enabled timer, comparator high, calendar or voltage event wakes the device.
// - Either edge on an enabled port pin wakes the device.
// - A port pin still changed at recovery end with interrupt enabled raises it once interrupts return.
// - Port data freezes in stop; only levels lasting to recovery end are seen.
// - Filtered low on reset pin in stop gives full system reset.
// - Low on debug pin in stop gives full system reset.
// - Reading status clears its upper four flags, not the low-voltage flag.
module stop_recovery_reset_indicator
  import stop_recovery_pkg::*;
(
  input  wire logic        sys_clk,                 // System clock, 10 MHz.
  input  wire logic        nrst,                    // Asynchronous reset, active low.
  input  wire logic [4:0]  avs_address,             // Avalon byte address.
  input  wire logic        avs_read,                // Avalon read request.
  input  wire logic        avs_write,               // Avalon write request.
  input  wire logic [31:0] avs_writedata,           // Avalon write data.
  output logic      [31:0] avs_readdata,            // Avalon read data.
  output logic             avs_waitrequest,         // Avalon wait request.
  input  wire logic        reset_pin_in,            // Reset pin level.
  output logic             reset_pin_out,           // Reset pin drive value.
  output logic             reset_pin_oe_n,          // Reset pin drive enable, low drives.
  input  wire logic        debug_pin_in,            // Debug pin level.
  input  wire logic        por_event,               // Power-on or brown-out reset pulse.
  input  wire logic        wdt_timeout,             // Watchdog time-out pulse.
  input  wire logic        timer_event,             // Timer interrupt assertion.
  input  wire logic        comparator_out,          // Comparator output.
  input  wire logic        rtc_event,               // Calendar clock interrupt.
  input  wire logic        lvd_event,               // Low-voltage detector interrupt.
  input  wire logic        lvd_level,               // Supply below low-voltage threshold.
  input  wire logic [7:0]  port_pins,               // Port pin levels.
  output logic             system_reset,            // Reset to all but the debugger.
  output logic             cpu_hold,                // Processor held idle.
  output logic             vector_fetch,            // Restart vector byte fetch strobe.
  output logic      [15:0] vector_addr,             // Restart vector byte address.
  output logic             dco_select,              // Oscillator is the system clock.
  output logic             dco_load,                // Load oscillator code strobe.
  output logic      [7:0]  dco_code,                // Oscillator delay code.
  output logic             frequency_locked_loop,   // Frequency loop enable.
  output logic             osc_run,                 // Precision or crystal source runs.
  output logic             stop_mode,               // Device in stop mode.
  output logic             global_interrupt_enable, // Interrupt enable.
  output logic             wdt_irq,                 // Watchdog interrupt request.
  output logic      [7:0]  port_irq,                // Port interrupt requests.
  output logic      [7:0]  port_input_data          // Port input data.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    seq_state_t  state;
    logic        waitreq;
    logic [31:0] rdata;
    logic        por;
    logic        stp;
    logic        wdt;
    logic        ext;
    logic        low_voltage_detector;
    logic [9:0]  ctrl;
    logic [3:0]  wake_en;
    logic [7:0]  port_wake_en;
    logic [7:0]  port_irq_en;
    logic [7:0]  port_pend;
    logic [7:0]  port_snap;
    logic [7:0]  port_in;
    logic [7:0]  digitally_controlled_oscillator;
    logic        dco_load;
    logic        tstart;
    logic [15:0] tcount;
    logic        delay_done;
    logic        from_dbg;
    logic        wdt_irq;
    logic        fetch;
    logic [15:0] vaddr;
    logic        sysrst;
    logic        hold;
    logic        pin_oe_n;
    logic        osc_run;
    logic [7:0]  port_irq;
  } seq_t;

  localparam seq_t SEQ_RESET = '{
    state: RUN, waitreq: 1'b1, ctrl: 10'(1 << CT_OSC_EN), digitally_controlled_oscillator: DCO_CODE_RESET,
    pin_oe_n: 1'b1, osc_run: 1'b1, default: '0};

  seq_t s;
  seq_t next_s;

  delay_timer_if tmr ();
  logic          pin_low;
  logic          req;
  logic          rd_acc;
  logic          wr_acc;
  logic          go_reset;
  logic          wake;
  logic [7:0]    edges;

  delay_timer u_timer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tmr     (tmr.timer)
  );

  // Our own drive of the pin reads back low, so it is masked from the filter.
  pin_low_filter u_pin_filter (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pin_n    (reset_pin_in | ~s.pin_oe_n),
    .low_seen (pin_low)
  );

  assign tmr.start = s.tstart;
  assign tmr.count = s.tcount;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.dco_load = 1'b0;
    next_s.tstart   = 1'b0;
    next_s.fetch    = 1'b0;
    next_s.low_voltage_detector      = lvd_level;
    go_reset        = 1'b0;
    wake            = 1'b0;
    edges           = (port_pins ^ s.port_snap) & s.port_wake_en;

    // Bus slave: one wait cycle, then the access is taken.
    req            = avs_read | avs_write;
    rd_acc         = avs_read & ~s.waitreq;
    wr_acc         = avs_write & ~s.waitreq;
    next_s.waitreq = ~(req & s.waitreq);
    if (avs_read && s.waitreq) begin
      unique case (avs_address)
        ADDR_STATUS:  next_s.rdata = {24'h0000_00, s.por, s.stp, s.wdt, s.ext, 3'h0, s.low_voltage_detector};
        ADDR_CONTROL: next_s.rdata = {22'h00_0000, s.ctrl};
        ADDR_WAKE:    next_s.rdata = {16'h0000, s.port_wake_en, 4'h0, s.wake_en};
        ADDR_PORT:    next_s.rdata = {8'h00, s.port_in, s.port_pend, s.port_irq_en};
        ADDR_CLOCK:   next_s.rdata = {16'h0000, 5'h00, s.state, s.digitally_controlled_oscillator};
        default:      next_s.rdata = 32'h0000_0000;
      endcase
    end

    if (rd_acc && avs_address == ADDR_STATUS) begin
      next_s.por     = 1'b0;
      next_s.stp     = 1'b0;
      next_s.wdt     = 1'b0;
      next_s.ext     = 1'b0;
      next_s.wdt_irq = 1'b0;
    end
    if (wr_acc) begin
      unique case (avs_address)
        ADDR_CONTROL: next_s.ctrl = avs_writedata[9:0];
        ADDR_WAKE: begin
          next_s.wake_en      = avs_writedata[3:0];
          next_s.port_wake_en = avs_writedata[15:8];
        end
        ADDR_PORT: begin
          next_s.port_irq_en = avs_writedata[7:0];
          next_s.port_pend   = s.port_pend & ~avs_writedata[15:8];
        end
        ADDR_CLOCK: next_s.digitally_controlled_oscillator = avs_writedata[7:0];
        default: ;
      endcase
    end

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    unique case (s.state)
      RUN: begin
        // Hold lasts through the second vector byte and drops with it.
        next_s.hold    = 1'b0;
        next_s.port_in = port_pins;
        if (wdt_timeout) begin
          next_s.wdt = 1'b1;
          if (s.ctrl[CT_WDT_IRQ]) begin
            next_s.wdt_irq = 1'b1;
          end else begin
            go_reset = 1'b1;
          end
        end
        if (next_s.ctrl[CT_STOP]) begin
          next_s.state          = STOP;
          next_s.ctrl[CT_STOP]  = 1'b0;
          next_s.ctrl[CT_FLL]   = 1'b0;
          next_s.port_snap      = port_pins;
          next_s.hold           = 1'b1;
        end
      end
      STOP: begin
        wake = wdt_timeout
             | (|(s.wake_en & {lvd_event, rtc_event, comparator_out, timer_event}))
             | (|edges);
        // Debug pin low outranks any wake source.
        if (debug_pin_in == 1'b0) begin
          go_reset = 1'b1;
        end else if (wake) begin
          next_s.state          = RECOVER;
          next_s.stp            = 1'b1;
          next_s.ctrl[CT_GIE]   = 1'b0;
          next_s.ctrl[CT_FLL]   = 1'b0;
          next_s.ctrl[CT_CLK_ALT] = 1'b0;
          next_s.dco_load       = 1'b1;
          next_s.tstart         = 1'b1;
          next_s.tcount         = s.ctrl[CT_FAST] ? FAST_RECOV_COUNT
                                                  : SLOW_RECOV_COUNT;
          if (wdt_timeout) begin
            next_s.wdt     = 1'b1;
            next_s.wdt_irq = s.ctrl[CT_WDT_IRQ];
          end
        end
      end
      RECOVER: begin
        if (tmr.done) begin
          next_s.state     = FETCH_HI;
          next_s.port_in   = port_pins;
          next_s.port_pend = next_s.port_pend
                           | ((port_pins ^ s.port_snap) & s.port_irq_en);
        end
      end
      FETCH_HI: begin
        next_s.fetch = 1'b1;
        next_s.vaddr = VECTOR_ADDR_HI;
        next_s.state = FETCH_LO;
      end
      FETCH_LO: begin
        next_s.fetch = 1'b1;
        next_s.vaddr = VECTOR_ADDR_LO;
        next_s.state = RUN;
      end
      SYS_RESET: begin
        next_s.ctrl[CT_DBG_RST] = 1'b0;
        if (tmr.done) begin
          next_s.delay_done = 1'b1;
        end
        // Leave once the delay is over and the pin is free.
        if ((s.delay_done || tmr.done) && !pin_low) begin
          next_s.state  = FETCH_HI;
          next_s.sysrst = 1'b0;
          if (s.from_dbg) begin
            next_s.por = 1'b1;
          end
        end
      end
      // An unused state code cannot be left in place,
      // so it restarts the chip.
      default: begin
        go_reset = 1'b1;
      end
    endcase

    // A power-on event restarts the reset delay even in reset; other sources start it only from outside reset.
    if (por_event) begin
      go_reset   = 1'b1;
      next_s.por = 1'b1;
    end
    if (pin_low && s.state != SYS_RESET) begin
      go_reset   = 1'b1;
      next_s.ext = 1'b1;
    end
    if (s.ctrl[CT_DBG_RST] && s.state != SYS_RESET) begin
      go_reset = 1'b1;
    end
    if (go_reset) begin
      next_s.state        = SYS_RESET;
      next_s.from_dbg     = s.ctrl[CT_DBG_RST] && !por_event;
      next_s.ctrl         = SEQ_RESET.ctrl;
      next_s.wake_en      = '0;
      next_s.port_wake_en = '0;
      next_s.port_irq_en  = '0;
      next_s.port_pend    = '0;
      next_s.wdt_irq      = 1'b0;
      next_s.digitally_controlled_oscillator          = DCO_CODE_RESET;
      next_s.sysrst       = 1'b1;
      next_s.hold         = 1'b1;
      next_s.delay_done   = 1'b0;
      next_s.tstart       = 1'b1;
      next_s.tcount       = RESET_DELAY_COUNT;
    end

    // Outputs, taken from the next state so that each sits in a flip-flop.
    next_s.pin_oe_n = ~(next_s.state == SYS_RESET || next_s.ctrl[CT_PIN_OUT]);
    next_s.osc_run  = next_s.ctrl[CT_OSC_EN]
                    & (next_s.state != STOP || next_s.ctrl[CT_KEEP]);
    next_s.port_irq = next_s.port_pend & {PORT_COUNT{next_s.ctrl[CT_GIE]}};
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= SEQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign avs_readdata            = s.rdata;
  assign avs_waitrequest         = s.waitreq;
  assign reset_pin_out           = 1'b0;
  assign reset_pin_oe_n          = s.pin_oe_n;
  assign system_reset            = s.sysrst;
  assign cpu_hold                = s.hold;
  assign vector_fetch            = s.fetch;
  assign vector_addr             = s.vaddr;
  assign dco_select              = ~s.ctrl[CT_CLK_ALT];
  assign dco_load                = s.dco_load;
  assign dco_code                = s.digitally_controlled_oscillator;
  assign frequency_locked_loop   = s.ctrl[CT_FLL];
  assign osc_run                 = s.osc_run;
  assign stop_mode               = (s.state == STOP);
  assign global_interrupt_enable = s.ctrl[CT_GIE];
  assign wdt_irq                 = s.wdt_irq;
  assign port_irq                = s.port_irq;
  assign port_input_data         = s.port_in;

endmodule
